/* File: verilog/uie_pkg.sv */
// Purpose: Constants and carrier types for the UART interrupt-enable and status block
// Assumes: Eight-bit register port, synchronous strobes, one clock
// Notes: Enhanced registers are visible only under the special line control value
//
// Notes on behaviour
// - FIFO and receive enable on: receive interrupt while fill is at or above trigger.
// - Source code shows receive level; it and the interrupt clear together below trigger.
// - Data-ready bit sets on any character entering the FIFO, clears when empty.
// - FIFOs on and mask bits 0-3 clear gives polled mode.
// - Overrun bit sets on receive overrun; FIFO contents may be invalid.
// - Status bits 2-4 show errors of the character at the holding position.
// - Bit 5 while holding register empty; bit 6 while FIFO and shifter empty.
// - Bit 7 set while any character in the receive FIFO carries an error.
// - Receive interrupt: character present without FIFO, trigger reached with FIFO.
// - Transmit interrupt: holding empties without FIFO, fill below trigger with FIFO.
// - Enabling transmit interrupt while holding register empty raises it at once.
// - Line-status interrupt while an overrun or a latched character error event is pending.
// - Overrun raises line-status interrupt as soon as the character arrives.
// - Errors interrupt on read-out by default, on reception when mode bit 6 set.
// - Modem-status enable passes modem change interrupts; masked when clear.
// - Sleep enable bit allows sleep; writable only with enhanced bit 4 set.
// - Enabled interrupt causes are reported in the interrupt source register.
// - Source bit 0 reads zero while pending, one when idle.
// - Status read clears line-status interrupt; holding read clears time-out.

package uie_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [2:0] ADDR_HOLD = 3'h0;
	localparam logic [2:0] ADDR_MASK = 3'h1;
	localparam logic [2:0] ADDR_SRC = 3'h2;
	localparam logic [2:0] ADDR_LCTL = 3'h3;
	localparam logic [2:0] ADDR_LSTATE = 3'h5;
	localparam logic [2:0] ADDR_MODEM = 3'h6;
	localparam logic [2:0] ADDR_SPARE = 3'h7;
	localparam logic [2:0] ADDR_TRG = 3'h0;
	localparam logic [2:0] ADDR_FCTL = 3'h1;
	localparam logic [2:0] ADDR_EFR = 3'h2;
	localparam logic [2:0] ADDR_RES1 = 3'h4;
	localparam logic [2:0] ADDR_RES2 = 3'h5;
	localparam logic [2:0] ADDR_PAU1 = 3'h6;
	localparam logic [2:0] ADDR_PAU2 = 3'h7;
	localparam logic [7:0] LCTL_SPECIAL = 8'hbf;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int EFR_ENH_BIT = 4;
	localparam int LCTL_DIV_BIT = 7;
	localparam int FCTL_EMS_BIT = 6;
	localparam int EMS_IMMED_BIT = 6;
	localparam int MASK_SLEEP_BIT = 4;
	// ****************************************
	// Reset values and source codes
	// ****************************************
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [5:0] SRC_LINE = 6'h06;
	localparam logic [5:0] SRC_TMO = 6'h0c;
	localparam logic [5:0] SRC_RXRDY = 6'h04;
	localparam logic [5:0] SRC_TXRDY = 6'h02;
	localparam logic [5:0] SRC_MODEM = 6'h00;
	localparam logic [5:0] SRC_NONE = 6'h01;
	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic cs;
		logic rd;
		logic wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} uie_bus_t;
	typedef struct packed {
		logic [7:0] rx_count;
		logic [7:0] rx_head;
		logic [2:0] rx_head_err;
		logic rx_push;
		logic [2:0] rx_push_err;
		logic overrun;
		logic rx_timeout;
		logic [7:0] tx_count;
		logic tx_shift_empty;
		logic [3:0] modem_delta;
	} uie_line_t;
endpackage : uie_pkg

/* File: verilog/uie_core.sv */
// Purpose: Interrupt enable, interrupt source and line status logic of a FIFO UART
// Assumes: Strobes are one-cycle pulses synchronous to clk_sys_in
// Notes: Read data and side effects take effect on the strobe's edge
`timescale 1ns/1ps

module uie_core (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire uie_pkg::uie_bus_t bus_in,
	input wire uie_pkg::uie_line_t line_in,
	output logic [7:0] rdata_out,
	output logic irq_out,
	output logic sleep_enable_out,
	output logic fifo_enable_out,
	output logic polled_mode_out,
	output logic rx_fifo_reset_out,
	output logic tx_fifo_reset_out,
	output logic rx_pop_out,
	output logic tx_push_out,
	output logic [7:0] tx_data_out
);
	import uie_pkg::*;

	// ****************************************
	// Trigger decoding
	// ****************************************
	function automatic logic [7:0] trig_level(input logic [1:0] table_sel, input logic [1:0] sel,
			input logic is_tx, input logic [7:0] prog);
		logic [7:0] lvl;
		lvl = 8'h01;
		case (table_sel)
			2'h0: begin
				if (!is_tx) begin
					case (sel)
						2'h0: lvl = 8'h01;
						2'h1: lvl = 8'h04;
						2'h2: lvl = 8'h08;
						default: lvl = 8'h0e;
					endcase
				end
			end
			2'h1: begin
				case ({is_tx, sel})
					3'h0: lvl = 8'h08;
					3'h1: lvl = 8'h10;
					3'h2: lvl = 8'h18;
					3'h3: lvl = 8'h1c;
					3'h4: lvl = 8'h10;
					3'h5: lvl = 8'h08;
					3'h6: lvl = 8'h18;
					default: lvl = 8'h1e;
				endcase
			end
			default: lvl = prog;
		endcase
		return lvl;
	endfunction : trig_level

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] line_control;
	logic [7:0] interrupt_mask;
	logic [7:0] enhanced_feature;
	logic [7:0] feature_control;
	logic [7:0] extended_mode_select;
	logic [7:0] tx_trigger_level_write;
	logic [7:0] resume_char_one;
	logic [7:0] resume_char_two;
	logic [7:0] pause_char_one;
	logic [7:0] pause_char_two;
	logic [7:0] scratch;
	logic fifo_en;
	logic [1:0] rx_trig_sel;
	logic [1:0] tx_trig_sel;
	logic overrun_flag;
	logic line_evt;
	logic tmo_flag;
	logic tx_flag;
	logic tx_cond_d;
	logic [7:0] err_count;

	// ****************************************
	// Address decode
	// ****************************************
	wire special = (line_control == LCTL_SPECIAL);
	wire divisor = line_control[LCTL_DIV_BIT];
	wire enh = enhanced_feature[EFR_ENH_BIT];
	wire rd = bus_in.cs && bus_in.rd;
	wire wr = bus_in.cs && bus_in.wr;
	wire normal = !special && !divisor;
	wire rd_hold = rd && normal && bus_in.addr == ADDR_HOLD;
	wire wr_hold = wr && normal && bus_in.addr == ADDR_HOLD;
	wire wr_mask = wr && normal && bus_in.addr == ADDR_MASK;
	wire rd_src = rd && !special && bus_in.addr == ADDR_SRC;
	wire wr_fifo = wr && !special && bus_in.addr == ADDR_SRC;
	wire wr_lctl = wr && bus_in.addr == ADDR_LCTL;
	wire rd_lstate = rd && !special && bus_in.addr == ADDR_LSTATE;
	wire wr_spare = wr && !special && bus_in.addr == ADDR_SPARE;
	wire wr_ems = wr_spare && feature_control[FCTL_EMS_BIT];
	wire wr_enh = wr && special;

	// ****************************************
	// Status terms
	// ****************************************
	wire [7:0] rx_trig = trig_level(feature_control[5:4], rx_trig_sel, 1'b0, tx_trigger_level_write);
	wire [7:0] tx_trig = trig_level(feature_control[5:4], tx_trig_sel, 1'b1, tx_trigger_level_write);
	wire rx_any = (line_in.rx_count != 8'h00);
	wire [2:0] head_err = rx_any ? line_in.rx_head_err : 3'h0;
	wire tx_empty = (line_in.tx_count == 8'h00);
	wire [7:0] line_state = {(err_count != 8'h00), tx_empty && line_in.tx_shift_empty, tx_empty,
		head_err, overrun_flag, rx_any};
	wire pop = rd_hold && rx_any;
	wire push_err = line_in.rx_push && (line_in.rx_push_err != 3'h0);
	wire pop_err = pop && (line_in.rx_head_err != 3'h0);
	wire immed = extended_mode_select[EMS_IMMED_BIT];
	wire line_set = (immed ? push_err : pop_err);
	wire rx_cond = fifo_en ? (line_in.rx_count >= rx_trig) : rx_any;
	wire tx_cond = fifo_en ? (line_in.tx_count < tx_trig) : tx_empty;

	// ****************************************
	// Pending causes through the mask
	// ****************************************
	wire pend_line = interrupt_mask[2] && (overrun_flag || line_evt);
	wire pend_tmo = interrupt_mask[0] && tmo_flag;
	wire pend_rx = interrupt_mask[0] && rx_cond;
	wire pend_tx = interrupt_mask[1] && tx_flag;
	wire pend_modem = interrupt_mask[3] && (line_in.modem_delta != 4'h0);
	wire pending = pend_line || pend_tmo || pend_rx || pend_tx || pend_modem;
	wire [5:0] src_code = pend_line ? SRC_LINE : pend_tmo ? SRC_TMO : pend_rx ? SRC_RXRDY :
		pend_tx ? SRC_TXRDY : pend_modem ? SRC_MODEM : SRC_NONE;
	wire [7:0] interrupt_source = {fifo_en, fifo_en, src_code};
	wire [7:0] mask_wdata = enh ? bus_in.wdata : {interrupt_mask[7:4], bus_in.wdata[3:0]};
	wire tx_enable_rise = wr_mask && bus_in.wdata[1] && !interrupt_mask[1];

	// ****************************************
	// Read data selection
	// ****************************************
	logic [7:0] next_rdata;
	always_comb begin
		next_rdata = 8'h00;
		if (special) begin
			case (bus_in.addr)
				ADDR_TRG: next_rdata = extended_mode_select[0] ? line_in.tx_count : line_in.rx_count;
				ADDR_FCTL: next_rdata = feature_control;
				ADDR_EFR: next_rdata = enhanced_feature;
				ADDR_RES1: next_rdata = resume_char_one;
				ADDR_RES2: next_rdata = resume_char_two;
				ADDR_PAU1: next_rdata = pause_char_one;
				ADDR_PAU2: next_rdata = pause_char_two;
				default: next_rdata = 8'h00;
			endcase
		end else begin
			case (bus_in.addr)
				ADDR_HOLD: next_rdata = divisor ? 8'h00 : line_in.rx_head;
				ADDR_MASK: next_rdata = divisor ? 8'h00 : interrupt_mask;
				ADDR_SRC: next_rdata = interrupt_source;
				ADDR_LCTL: next_rdata = line_control;
				ADDR_LSTATE: next_rdata = line_state;
				ADDR_MODEM: next_rdata = {4'h0, line_in.modem_delta};
				ADDR_SPARE: next_rdata = feature_control[FCTL_EMS_BIT] ? line_in.rx_count : scratch;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			line_control <= RST_ZERO;
			interrupt_mask <= RST_ZERO;
			scratch <= RST_ZERO;
		end else begin
			if (wr_lctl)
				line_control <= bus_in.wdata;
			if (wr_mask)
				interrupt_mask <= mask_wdata;
			if (wr_spare && !feature_control[FCTL_EMS_BIT])
				scratch <= bus_in.wdata;
		end
	end

	// Enhanced registers, special line control only
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			enhanced_feature <= RST_ZERO;
			feature_control <= RST_ZERO;
			tx_trigger_level_write <= RST_ZERO;
			resume_char_one <= RST_ZERO;
			resume_char_two <= RST_ZERO;
			pause_char_one <= RST_ZERO;
			pause_char_two <= RST_ZERO;
		end else if (wr_enh) begin
			case (bus_in.addr)
				ADDR_TRG: tx_trigger_level_write <= bus_in.wdata;
				ADDR_FCTL: feature_control <= bus_in.wdata;
				ADDR_EFR: enhanced_feature <= bus_in.wdata;
				ADDR_RES1: resume_char_one <= bus_in.wdata;
				ADDR_RES2: resume_char_two <= bus_in.wdata;
				ADDR_PAU1: pause_char_one <= bus_in.wdata;
				ADDR_PAU2: pause_char_two <= bus_in.wdata;
				default: ;
			endcase
		end
	end

	// FIFO setup and extended mode
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			fifo_en <= 1'b0;
			rx_trig_sel <= 2'h0;
			tx_trig_sel <= 2'h0;
			extended_mode_select <= RST_ZERO;
		end else begin
			if (wr_fifo) begin
				fifo_en <= bus_in.wdata[0];
				if (bus_in.wdata[0])
					rx_trig_sel <= bus_in.wdata[7:6];
				if (bus_in.wdata[0] && enh)
					tx_trig_sel <= bus_in.wdata[5:4];
			end
			if (wr_ems && enh)
				extended_mode_select <= bus_in.wdata;
		end
	end

	// ****************************************
	// Sticky event flags, set wins over clear
	// ****************************************
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			overrun_flag <= 1'b0;
			line_evt <= 1'b0;
			tmo_flag <= 1'b0;
			tx_flag <= 1'b0;
			tx_cond_d <= 1'b1; // Idle level of an empty holder, no false edge
		end else begin
			overrun_flag <= line_in.overrun || (overrun_flag && !rd_lstate);
			line_evt <= line_set || (line_evt && !rd_lstate);
			tmo_flag <= line_in.rx_timeout || (tmo_flag && !rd_hold);
			tx_cond_d <= tx_cond;
			if ((tx_cond && !tx_cond_d) || (tx_enable_rise && tx_cond))
				tx_flag <= 1'b1;
			else if (wr_hold || (rd_src && src_code == SRC_TXRDY) || !tx_cond)
				tx_flag <= 1'b0;
		end
	end

	// Count of erroneous characters held in the receive FIFO
	always_ff @(posedge clk_sys_in) begin
		if (reset_in || (wr_fifo && bus_in.wdata[1] && bus_in.wdata[0]))
			err_count <= 8'h00;
		else if (push_err && !pop_err)
			err_count <= err_count + 8'h01;
		else if (pop_err && !push_err && err_count != 8'h00)
			err_count <= err_count - 8'h01;
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			rdata_out <= 8'h00;
			irq_out <= 1'b0;
			sleep_enable_out <= 1'b0;
			fifo_enable_out <= 1'b0;
			polled_mode_out <= 1'b0;
			rx_fifo_reset_out <= 1'b0;
			tx_fifo_reset_out <= 1'b0;
			rx_pop_out <= 1'b0;
			tx_push_out <= 1'b0;
			tx_data_out <= 8'h00;
		end else begin
			if (rd)
				rdata_out <= next_rdata;
			irq_out <= pending;
			sleep_enable_out <= interrupt_mask[MASK_SLEEP_BIT];
			fifo_enable_out <= fifo_en;
			polled_mode_out <= fifo_en && (interrupt_mask[3:0] == 4'h0);
			rx_fifo_reset_out <= wr_fifo && bus_in.wdata[0] && bus_in.wdata[1];
			tx_fifo_reset_out <= wr_fifo && bus_in.wdata[0] && bus_in.wdata[2];
			rx_pop_out <= pop;
			tx_push_out <= wr_hold;
			if (wr_hold)
				tx_data_out <= bus_in.wdata;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_lstate_read;
		rd_lstate;
	endsequence
	sequence s_quiet_line;
		!line_in.overrun && !line_set;
	endsequence

	property p_rx_level;
		@(posedge clk_sys_in) disable iff (reset_in)
		(fifo_en && interrupt_mask[0] && line_in.rx_count >= rx_trig) |=> irq_out;
	endproperty
	a_rx_level: assert property (p_rx_level) else $error("receive level without interrupt");

	property p_rx_code;
		@(posedge clk_sys_in) disable iff (reset_in)
		(rd_src && pend_rx && !pend_line && !pend_tmo) |=> rdata_out[3:0] == 4'h4;
	endproperty
	a_rx_code: assert property (p_rx_code) else $error("wrong receive level code");

	property p_ready;
		@(posedge clk_sys_in) disable iff (reset_in)
		s_lstate_read |=> rdata_out[0] == $past(rx_any);
	endproperty
	a_ready: assert property (p_ready) else $error("data ready bit wrong");

	property p_overrun;
		@(posedge clk_sys_in) disable iff (reset_in)
		line_in.overrun ##1 s_lstate_read |=> rdata_out[1];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun bit not shown");

	property p_tx_bits;
		@(posedge clk_sys_in) disable iff (reset_in)
		(s_lstate_read and tx_empty) |=> rdata_out[5] && (rdata_out[6] == $past(line_in.tx_shift_empty));
	endproperty
	a_tx_bits: assert property (p_tx_bits) else $error("transmit empty bits wrong");

	property p_global_err;
		@(posedge clk_sys_in) disable iff (reset_in)
		(s_lstate_read and err_count != 8'h00) |=> rdata_out[7];
	endproperty
	a_global_err: assert property (p_global_err) else $error("global error bit missing");

	property p_tx_enable;
		@(posedge clk_sys_in) disable iff (reset_in)
		(tx_enable_rise && tx_cond && !wr_hold) |=> tx_flag ##1 (irq_out || !interrupt_mask[1]);
	endproperty
	a_tx_enable: assert property (p_tx_enable) else $error("transmit enable not immediate");

	property p_overrun_irq;
		@(posedge clk_sys_in) disable iff (reset_in)
		(line_in.overrun && interrupt_mask[2] && !wr_mask) |=> ##1 irq_out;
	endproperty
	a_overrun_irq: assert property (p_overrun_irq) else $error("overrun interrupt late");

	property p_idle_code;
		@(posedge clk_sys_in) disable iff (reset_in)
		(rd_src && !pending) |=> rdata_out[0];
	endproperty
	a_idle_code: assert property (p_idle_code) else $error("idle source bit not one");

	property p_line_clear;
		@(posedge clk_sys_in) disable iff (reset_in)
		(s_lstate_read and s_quiet_line) |=> !overrun_flag && !line_evt;
	endproperty
	a_line_clear: assert property (p_line_clear) else $error("status read did not clear");

	property p_gate;
		@(posedge clk_sys_in) disable iff (reset_in)
		(wr_mask && !enh) |=> $stable(interrupt_mask[7:4]);
	endproperty
	a_gate: assert property (p_gate) else $error("upper mask written without enable");
endmodule : uie_core

/* File: testbench/uie_line_model.sv */
// Purpose: Behavioural serial-side model feeding FIFO levels and events to the block
// Assumes: Pop and push strobes are one-cycle pulses from the block
// Notes: Events are requested by tasks and applied just after the next edge
`timescale 1ns/1ps

module uie_line_model (
	input wire logic clk_sys_in,
	input wire logic rx_pop_in,
	input wire logic tx_push_in,
	output uie_pkg::uie_line_t line_out
);
	import uie_pkg::*;
	// ****************************************
	// State
	// ****************************************
	logic [10:0] rxq[$];
	logic [7:0] last_head;
	logic [3:0] shift_busy;
	logic pop, push, pend_push, pend_ovr, pend_tmo;
	logic take_push, take_ovr, take_tmo;
	logic [10:0] pend_char;
	logic [10:0] take_char;
	initial begin
		line_out = '0;
		line_out.tx_shift_empty = 1'b1;
		last_head = 8'h00;
		shift_busy = 4'h0;
		pend_push = 1'b0;
		pend_ovr = 1'b0;
		pend_tmo = 1'b0;
		pend_char = 11'h000;
	end
	// ****************************************
	// Requests from the bench
	// ****************************************
	task automatic push_char(input logic [7:0] d, input logic [2:0] e);
		pend_char = {e, d};
		pend_push = 1'b1;
		@(posedge clk_sys_in);
		#1;
	endtask : push_char
	task automatic overrun_pulse();
		pend_ovr = 1'b1;
		@(posedge clk_sys_in);
		#1;
	endtask : overrun_pulse
	task automatic timeout_pulse();
		pend_tmo = 1'b1;
		@(posedge clk_sys_in);
		#1;
	endtask : timeout_pulse
	task automatic set_modem(input logic [3:0] v);
		line_out.modem_delta = v;
	endtask : set_modem
	// FIFO levels, drained head shows a toggled pattern
	always @(posedge clk_sys_in) begin
		pop = rx_pop_in;
		push = tx_push_in;
		take_push = pend_push;
		take_ovr = pend_ovr;
		take_tmo = pend_tmo;
		take_char = pend_char;
		pend_push = 1'b0;
		pend_ovr = 1'b0;
		pend_tmo = 1'b0;
		// Event pulses change just after the edge, never on it
		#1;
		line_out.rx_push = take_push;
		line_out.rx_push_err = take_push ? take_char[10:8] : 3'h0;
		line_out.overrun = take_ovr;
		line_out.rx_timeout = take_tmo;
		if (take_push) begin
			rxq.push_back(take_char);
		end
		if (pop && rxq.size() > 0) begin
			last_head = rxq[0][7:0];
			void'(rxq.pop_front());
		end
		if (push) begin
			line_out.tx_count = line_out.tx_count + 8'h01;
		end else if (shift_busy == 4'h0 && line_out.tx_count != 8'h00) begin
			line_out.tx_count = line_out.tx_count - 8'h01;
			shift_busy = 4'hf;
		end else if (shift_busy != 4'h0) begin
			shift_busy = shift_busy - 4'h1;
		end
		line_out.tx_shift_empty = (shift_busy == 4'h0);
		line_out.rx_count = 8'(rxq.size());
		line_out.rx_head = (rxq.size() > 0) ? rxq[0][7:0] : ~last_head;
		line_out.rx_head_err = (rxq.size() > 0) ? rxq[0][10:8] : 3'h0;
	end
endmodule : uie_line_model

/* File: testbench/uart_interrupt_enable_and_polled_status_tb.sv */
// Purpose: Self-checking bench for interrupt enable and line status logic
// Assumes: Register accesses are one-cycle strobes on the block's own port
// Notes: Expected values follow the source codes and field positions of the package
`timescale 1ns/1ps

`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end

module uart_interrupt_enable_and_polled_status_tb;
	import uie_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic clk_sys_in, reset_in;
	uie_bus_t bus;
	uie_line_t line;
	logic [7:0] rdata_out, tx_data_out;
	logic irq_out, sleep_enable_out, fifo_enable_out, polled_mode_out;
	logic rx_pop_out, tx_push_out;
	logic rx_fifo_reset_out, tx_fifo_reset_out;
	int n_rx_clr = 0;
	int n_tx_clr = 0;
	int failures = 0;
	int n_compared = 0;
	int cycles = 0;
	// ****************************************
	// Instances
	// ****************************************
	uie_core i_uie_core (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .bus_in(bus),
		.line_in(line), .rdata_out(rdata_out), .irq_out(irq_out),
		.sleep_enable_out(sleep_enable_out), .fifo_enable_out(fifo_enable_out),
		.polled_mode_out(polled_mode_out), .rx_fifo_reset_out(rx_fifo_reset_out),
		.tx_fifo_reset_out(tx_fifo_reset_out),
		.rx_pop_out(rx_pop_out), .tx_push_out(tx_push_out), .tx_data_out(tx_data_out));
	uie_line_model u_line (.clk_sys_in(clk_sys_in), .rx_pop_in(rx_pop_out),
		.tx_push_in(tx_push_out), .line_out(line));
	// Clock, 8 ns period
	initial begin
		clk_sys_in = 1'b0;
		forever #4 clk_sys_in = ~clk_sys_in;
	end
	// ****************************************
	// Tasks
	// ****************************************
	task automatic conclude();
		if (failures == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask : idle
	task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
		bus.cs = 1'b1;
		bus.wr = 1'b1;
		bus.addr = a;
		bus.wdata = d;
		idle(1);
		bus = '0;
		idle(1);
	endtask : bus_wr
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		bus.cs = 1'b1;
		bus.rd = 1'b1;
		bus.addr = a;
		idle(1);
		bus = '0;
		idle(1);
		`CHECK(rdata_out, exp)
	endtask : rd_chk
	// FIFO reset pulse counters, sampled mid-cycle
	always @(negedge clk_sys_in) begin
		if (rx_fifo_reset_out === 1'b1) n_rx_clr++;
		if (tx_fifo_reset_out === 1'b1) n_tx_clr++;
	end
	// Hang guard
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			conclude();
		end
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		reset_in = 1'b1;
		bus = '0;
		idle(20);
		reset_in = 1'b0;
		idle(1);
		rd_chk(ADDR_MASK, 8'h00);
		rd_chk(ADDR_SRC, 8'h01);
		rd_chk(ADDR_LSTATE, 8'h60);
		`CHECK(irq_out, 1'b0)
		// FIFO on, receive trigger four
		bus_wr(ADDR_SRC, 8'h41);
		`CHECK(fifo_enable_out, 1'b1)
		`CHECK(polled_mode_out, 1'b1)
		for (int i = 0; i < 3; i++) u_line.push_char(8'h30 + 8'(i), 3'h0);
		rd_chk(ADDR_LSTATE, 8'h61);
		bus_wr(ADDR_MASK, 8'h01);
		idle(2);
		`CHECK(irq_out, 1'b0)
		`CHECK(polled_mode_out, 1'b0)
		u_line.push_char(8'h33, 3'h0);
		idle(3);
		`CHECK(irq_out, 1'b1)
		rd_chk(ADDR_SRC, 8'hc4);
		rd_chk(ADDR_HOLD, 8'h30);
		idle(3);
		`CHECK(irq_out, 1'b0)
		rd_chk(ADDR_SRC, 8'hc1);
		for (int i = 1; i < 4; i++) rd_chk(ADDR_HOLD, 8'h30 + 8'(i));
		idle(2);
		rd_chk(ADDR_LSTATE, 8'h60);
		// Transmit ready, enabling while empty
		bus_wr(ADDR_MASK, 8'h02);
		idle(2);
		`CHECK(irq_out, 1'b1)
		rd_chk(ADDR_SRC, 8'hc2);
		idle(2);
		`CHECK(irq_out, 1'b0)
		bus_wr(ADDR_HOLD, 8'ha5);
		`CHECK(tx_data_out, 8'ha5)
		idle(4);
		rd_chk(ADDR_LSTATE, 8'h20);
		`CHECK(irq_out, 1'b1)
		idle(20);
		rd_chk(ADDR_LSTATE, 8'h60);
		// Overrun goes straight to the line interrupt
		bus_wr(ADDR_MASK, 8'h04);
		u_line.overrun_pulse();
		idle(3);
		`CHECK(irq_out, 1'b1)
		rd_chk(ADDR_SRC, 8'hc6);
		rd_chk(ADDR_LSTATE, 8'h62);
		idle(2);
		`CHECK(irq_out, 1'b0)
		rd_chk(ADDR_LSTATE, 8'h60);
		// Parity error reported on read-out by default
		u_line.push_char(8'h77, 3'h1);
		idle(3);
		`CHECK(irq_out, 1'b0)
		rd_chk(ADDR_LSTATE, 8'he5);
		rd_chk(ADDR_HOLD, 8'h77);
		idle(3);
		`CHECK(irq_out, 1'b1)
		rd_chk(ADDR_SRC, 8'hc6);
		rd_chk(ADDR_LSTATE, 8'h60);
		idle(2);
		`CHECK(irq_out, 1'b0)
		// Modem change passes only while enabled
		bus_wr(ADDR_MASK, 8'h08);
		u_line.set_modem(4'h1);
		idle(3);
		`CHECK(irq_out, 1'b1)
		rd_chk(ADDR_SRC, 8'hc0);
		bus_wr(ADDR_MASK, 8'h00);
		idle(2);
		`CHECK(irq_out, 1'b0)
		`CHECK(polled_mode_out, 1'b1)
		u_line.set_modem(4'h0);
		// Enhanced registers and gated mask bits
		bus_wr(ADDR_MASK, 8'h10);
		rd_chk(ADDR_MASK, 8'h00);
		`CHECK(sleep_enable_out, 1'b0)
		bus_wr(ADDR_LCTL, LCTL_SPECIAL);
		bus_wr(ADDR_EFR, 8'h10);
		rd_chk(ADDR_EFR, 8'h10);
		bus_wr(ADDR_RES1, 8'h5a);
		rd_chk(ADDR_RES1, 8'h5a);
		bus_wr(ADDR_FCTL, 8'h40);
		bus_wr(ADDR_LCTL, 8'h03);
		rd_chk(ADDR_RES1, 8'h00);
		bus_wr(ADDR_MASK, 8'h14);
		rd_chk(ADDR_MASK, 8'h14);
		`CHECK(sleep_enable_out, 1'b1)
		// Immediate error interrupt through extended mode
		bus_wr(ADDR_SPARE, 8'h40);
		u_line.push_char(8'h66, 3'h2);
		idle(3);
		`CHECK(irq_out, 1'b1)
		rd_chk(ADDR_LSTATE, 8'he9);
		rd_chk(ADDR_HOLD, 8'h66);
		// Time-out cleared by a holding read
		bus_wr(ADDR_MASK, 8'h11);
		u_line.push_char(8'h55, 3'h0);
		u_line.timeout_pulse();
		idle(3);
		`CHECK(irq_out, 1'b1)
		rd_chk(ADDR_SRC, 8'hcc);
		rd_chk(ADDR_HOLD, 8'h55);
		idle(2);
		`CHECK(irq_out, 1'b0)
		// Both FIFO resets, then receive interrupt without FIFO
		bus_wr(ADDR_SRC, 8'h07);
		`CHECK(n_rx_clr, 1)
		`CHECK(n_tx_clr, 1)
		bus_wr(ADDR_SRC, 8'h00);
		`CHECK(fifo_enable_out, 1'b0)
		u_line.push_char(8'h44, 3'h0);
		idle(3);
		`CHECK(irq_out, 1'b1)
		rd_chk(ADDR_SRC, 8'h04);
		rd_chk(ADDR_HOLD, 8'h44);
		idle(2);
		`CHECK(irq_out, 1'b0)
		conclude();
	end
endmodule : uart_interrupt_enable_and_polled_status_tb
